/* File: led_link_pkg.sv */
// shared constants and types for the smart led serial transmitter
package led_link_pkg;

	// ==========================================================
	// register map
	localparam logic [31:0] CTRL_ADDR = 32'hffff_ffd8;
	localparam logic [31:0] DATA_ADDR = 32'hffff_ffdc;

	// ==========================================================
	// protocol figures
	localparam logic [5:0] WORD_NARROW   = 6'h18;
	localparam logic [5:0] WORD_WIDE     = 6'h20;
	localparam logic [6:0] LATCH_PERIODS = 7'h7f;
	localparam logic [4:0] TICK_ONE      = 5'h01;

	// ==========================================================
	// control register layout, low bit last
	typedef struct packed {
		logic       txBusy;
		logic       txFull;
		logic       txHalf;
		logic       txEmpty;
		logic       irqConditionSelect;
		logic [1:0] reserved;
		logic [4:0] oneHighTime;
		logic [4:0] zeroHighTime;
		logic [4:0] bitPeriodMultiplier;
		logic [3:0] queueSizeLog2;
		logic [2:0] tickDividerSelect;
		logic       latchRequest;
		logic       wideMode;
		logic       enable;
	} ctrl_s;

	localparam ctrl_s CTRL_RESET = '0;

	// ==========================================================
	// queue entry and engine states
	typedef struct packed {
		logic        latch;
		logic        wide;
		logic [31:0] word;
	} entry_s;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_BIT   = 2'b01,
		ST_LATCH = 2'b11
	} state_e;

	// terminal count of the tick prescaler for each divider select
	function automatic logic [11:0] divTerminal(input logic [2:0] sel);
		case (sel)
			3'h0: divTerminal = 12'h001;
			3'h1: divTerminal = 12'h003;
			3'h2: divTerminal = 12'h007;
			3'h3: divTerminal = 12'h03f;
			3'h4: divTerminal = 12'h07f;
			3'h5: divTerminal = 12'h3ff;
			3'h6: divTerminal = 12'h7ff;
			default: divTerminal = 12'hfff;
		endcase
	endfunction

endpackage

/* File: smart_led_serial_tx.sv */
// smart led single-wire transmitter with apb registers and word queue
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/100ps

module smart_led_serial_tx #(
	parameter int DEPTH = 1
) (
	input  wire logic        clk_sys, // 200 MHz system clock
	input  wire logic        reset,   // synchronous, active high
	input  wire logic        clkEn,   // freezes all state when low
	input  wire logic [31:0] paddr,   // apb address
	input  wire logic        psel,    // apb select
	input  wire logic        penable, // apb enable
	input  wire logic        pwrite,  // apb direction
	input  wire logic [31:0] pwdata,  // apb write data
	output logic      [31:0] prdata,  // apb read data
	output logic             pready,  // apb ready
	output logic             pslverr, // apb error on unmapped address
	output logic             ledOut,  // serial line to the led chain
	output logic             irqReq   // one-cycle interrupt request
);

	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL_LVL = CW'(DEPTH);
	localparam logic [CW-1:0] HALF_LVL = CW'((DEPTH > 1) ? DEPTH / 2 : 1);
	localparam logic [3:0] DEPTH_LOG2 = 4'($clog2(DEPTH));

	// ==========================================================
	// apb slave and control register
	led_link_pkg::ctrl_s ctrlR, ctrlNxt, ctrlView;
	logic [31:0] prdata_r, prdata_nxt;
	logic        pready_r, pready_nxt, pslverr_r, pslverr_nxt;
	logic        access, done, hitCtrl, hitData, wrData;
	logic        confEff, emptyNow, halfNow, fullNow, busyNow;
	logic [CW-1:0] count_r, count_nxt;

	always_comb begin
		access  = psel & penable & ~pready_r;
		done    = psel & penable & pready_r;
		hitCtrl = 1'b0;
		hitData = 1'b0;
		if (paddr == led_link_pkg::CTRL_ADDR) begin
			hitCtrl = 1'b1;
		end else if (paddr == led_link_pkg::DATA_ADDR) begin
			hitData = 1'b1;
		end
		wrData   = done & pwrite & hitData;
		confEff  = (DEPTH == 1) ? 1'b1 : ctrlR.irqConditionSelect;
		emptyNow = count_r == '0;
		halfNow  = count_r >= HALF_LVL;
		fullNow  = count_r == FULL_LVL;
		ctrlView = ctrlR;
		ctrlView.queueSizeLog2      = DEPTH_LOG2;
		ctrlView.irqConditionSelect = confEff;
		ctrlView.txEmpty = emptyNow;
		ctrlView.txHalf  = halfNow;
		ctrlView.txFull  = fullNow;
		ctrlView.txBusy  = busyNow;
		ctrlNxt = ctrlR;
		if (done & pwrite & hitCtrl) begin
			ctrlNxt = pwdata;
			ctrlNxt.queueSizeLog2 = '0;
			ctrlNxt.reserved = '0;
			ctrlNxt.txEmpty = 1'b0;
			ctrlNxt.txHalf  = 1'b0;
			ctrlNxt.txFull  = 1'b0;
			ctrlNxt.txBusy  = 1'b0;
		end
		pready_nxt  = access;
		pslverr_nxt = access & ~(hitCtrl | hitData);
		prdata_nxt  = '0;
		if (access & ~pwrite & hitCtrl) begin
			prdata_nxt = ctrlView;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			ctrlR     <= led_link_pkg::CTRL_RESET;
			prdata_r  <= '0;
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
		end else if (clkEn) begin
			ctrlR     <= ctrlNxt;
			prdata_r  <= prdata_nxt;
			pready_r  <= pready_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	assign prdata  = prdata_r;
	assign pready  = pready_r;
	assign pslverr = pslverr_r;

	// ==========================================================
	// transmit queue
	led_link_pkg::entry_s mem_r [DEPTH];
	led_link_pkg::entry_s pushEntry, headEntry;
	logic [AW-1:0] wrPtr_r, wrPtr_nxt, rdPtr_r, rdPtr_nxt;
	logic          push, pop;

	always_comb begin
		push = wrData & ctrlR.enable & ~fullNow;
		pushEntry.latch = ctrlR.latchRequest;
		pushEntry.wide  = ctrlR.wideMode;
		pushEntry.word  = pwdata;
		headEntry = mem_r[rdPtr_r];
		wrPtr_nxt = wrPtr_r;
		rdPtr_nxt = rdPtr_r;
		count_nxt = count_r;
		if (push) begin
			wrPtr_nxt = (wrPtr_r == AW'(DEPTH - 1)) ? '0 : wrPtr_r + 1'b1;
		end
		if (pop) begin
			rdPtr_nxt = (rdPtr_r == AW'(DEPTH - 1)) ? '0 : rdPtr_r + 1'b1;
		end
		count_nxt = count_r + CW'(push) - CW'(pop);
		if (!ctrlR.enable) begin
			wrPtr_nxt = '0;
			rdPtr_nxt = '0;
			count_nxt = '0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
			count_r <= '0;
		end else if (clkEn) begin
			wrPtr_r <= wrPtr_nxt;
			rdPtr_r <= rdPtr_nxt;
			count_r <= count_nxt;
			if (push) begin
				mem_r[wrPtr_r] <= pushEntry;
			end
		end
	end

	// ==========================================================
	// serial engine
	led_link_pkg::state_e state_r, state_nxt;
	logic [31:0] shift_r, shift_nxt;
	logic [5:0]  bitsLeft_r, bitsLeft_nxt;
	logic [4:0]  tickCnt_r, tickCnt_nxt, highTime;
	logic [6:0]  periods_r, periods_nxt;
	logic [11:0] presc_r, presc_nxt, divMax;
	logic        led_r, led_nxt, tick, endPeriod;

	always_comb begin
		busyNow   = state_r != led_link_pkg::ST_IDLE;
		pop       = ctrlR.enable & ~busyNow & ~emptyNow;
		divMax    = led_link_pkg::divTerminal(ctrlR.tickDividerSelect);
		tick      = presc_r == divMax;
		endPeriod = tick & (tickCnt_r ==
			5'(ctrlR.bitPeriodMultiplier - led_link_pkg::TICK_ONE));
		state_nxt    = state_r;
		shift_nxt    = shift_r;
		bitsLeft_nxt = bitsLeft_r;
		periods_nxt  = periods_r;
		presc_nxt    = tick ? '0 : presc_r + 1'b1;
		tickCnt_nxt  = tick ? tickCnt_r + 1'b1 : tickCnt_r;
		case (state_r)
			led_link_pkg::ST_IDLE: begin
				presc_nxt   = '0;
				tickCnt_nxt = '0;
				periods_nxt = '0;
				if (pop) begin
					shift_nxt    = headEntry.word;
					bitsLeft_nxt = headEntry.wide ? led_link_pkg::WORD_WIDE
						: led_link_pkg::WORD_NARROW;
					state_nxt = headEntry.latch ? led_link_pkg::ST_LATCH
						: led_link_pkg::ST_BIT;
				end
			end
			led_link_pkg::ST_BIT: begin
				if (endPeriod) begin
					tickCnt_nxt  = '0;
					shift_nxt    = shift_r >> 1;
					bitsLeft_nxt = bitsLeft_r - 1'b1;
					if (bitsLeft_r == 6'h01) begin
						state_nxt = led_link_pkg::ST_IDLE;
					end
				end
			end
			default: begin
				if (endPeriod) begin
					tickCnt_nxt = '0;
					periods_nxt = periods_r + 1'b1;
					if (periods_nxt == led_link_pkg::LATCH_PERIODS) begin
						state_nxt = led_link_pkg::ST_IDLE;
					end
				end
			end
		endcase
		if (!ctrlR.enable) begin
			state_nxt = led_link_pkg::ST_IDLE;
		end
		highTime = shift_nxt[0] ? ctrlR.oneHighTime
			: ctrlR.zeroHighTime;
		led_nxt = (state_nxt == led_link_pkg::ST_BIT)
			& (tickCnt_nxt < highTime);
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			state_r    <= led_link_pkg::ST_IDLE;
			shift_r    <= '0;
			bitsLeft_r <= '0;
			tickCnt_r  <= '0;
			periods_r  <= '0;
			presc_r    <= '0;
			led_r      <= 1'b0;
		end else if (clkEn) begin
			state_r    <= state_nxt;
			shift_r    <= shift_nxt;
			bitsLeft_r <= bitsLeft_nxt;
			tickCnt_r  <= tickCnt_nxt;
			periods_r  <= periods_nxt;
			presc_r    <= presc_nxt;
			led_r      <= led_nxt;
		end
	end

	assign ledOut = led_r;

	// ==========================================================
	// fill-level interrupt
	logic halfPrev_r, emptyPrev_r, irq_r, irq_nxt;

	always_comb begin
		irq_nxt = ctrlR.enable & (confEff ? (emptyNow & ~emptyPrev_r)
			: (~halfNow & halfPrev_r));
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			halfPrev_r  <= 1'b0;
			emptyPrev_r <= 1'b1;
			irq_r       <= 1'b0;
		end else if (clkEn) begin
			halfPrev_r  <= halfNow;
			emptyPrev_r <= emptyNow;
			irq_r       <= irq_nxt;
		end
	end

	assign irqReq = irq_r;

	// ==========================================================
	// checks
	a_disable_line_low: assert property (@(posedge clk_sys) disable iff (reset)
		(clkEn && !ctrlR.enable) |=> !ledOut)
		else $error("line not low after disable");
	a_full_write_drop: assert property (@(posedge clk_sys) disable iff (reset)
		(clkEn && wrData && fullNow && !pop) |=> count_r == $past(count_r))
		else $error("write into full queue changed fill");
	a_push_grows: assert property (@(posedge clk_sys) disable iff (reset)
		(clkEn && push && !pop) |=> count_r == $past(count_r) + 1'b1)
		else $error("data write not queued");
	a_pop_starts: assert property (@(posedge clk_sys) disable iff (reset)
		(clkEn && pop) |=> state_r != led_link_pkg::ST_IDLE)
		else $error("pop did not start engine");
	a_latch_stays_low: assert property (@(posedge clk_sys) disable iff (reset)
		(state_r == led_link_pkg::ST_LATCH)[*2] |-> !ledOut)
		else $error("line high during latch idle");
	a_word_width: assert property (@(posedge clk_sys) disable iff (reset)
		(clkEn && pop && !headEntry.latch) |=>
		bitsLeft_r == ($past(headEntry.wide) ? led_link_pkg::WORD_WIDE
		: led_link_pkg::WORD_NARROW))
		else $error("wrong word width loaded");
	a_irq_cause: assert property (@(posedge clk_sys) disable iff (reset)
		irqReq |-> $past(ctrlR.enable) && ($past(confEff) ?
		$past(emptyNow) : !$past(halfNow)))
		else $error("interrupt without its fill condition");
	a_lsb_first: assert property (@(posedge clk_sys) disable iff (reset)
		(clkEn && ctrlR.enable && state_r == led_link_pkg::ST_BIT
		&& endPeriod) |=> shift_r == ($past(shift_r) >> 1))
		else $error("bits not shifted out low first");
	a_prescaler_bound: assert property (@(posedge clk_sys) disable iff (reset)
		(busyNow && ctrlR.enable) |-> presc_r <= divMax)
		else $error("prescaler past terminal count");

endmodule // smart_led_serial_tx

/* File: led_chain_model.sv */
// behavioural led chain that turns pulse widths back into bits
`timescale 1ns/100ps

module led_chain_model #(
	parameter int ONE_CLK  = 8,
	parameter int ZERO_CLK = 4
) (
	input wire logic clk_sys, // sampling clock
	input wire logic ledIn    // serial line from the transmitter
);
	// ==========================================================
	// decoded bits, oldest first
	logic bits[$];
	int   glitches   = 0;
	int   lastPeriod = 0;
	int   highLen    = 0;
	int   gap        = 0;
	logic prev       = 1'b0;

	// ==========================================================
	// pulse decoder
	always @(posedge clk_sys) begin
		gap = gap + 1;
		if (ledIn === 1'b1 && prev !== 1'b1) begin
			// rise to rise distance, long idle gaps ignored
			if (gap < 64)
				lastPeriod = gap;
			gap = 0;
		end
		if (ledIn === 1'b1) begin
			highLen = highLen + 1;
		end else if (prev === 1'b1) begin
			if (highLen == ONE_CLK)
				bits.push_back(1'b1);
			else if (highLen == ZERO_CLK)
				bits.push_back(1'b0);
			else
				glitches = glitches + 1;
			highLen = 0;
		end
		prev = ledIn;
	end
endmodule // led_chain_model

/* File: tb_smart_led_serial_tx.sv */
// self-checking testbench for the smart led serial transmitter
`timescale 1ns/100ps

module tb_smart_led_serial_tx;
	// ==========================================================
	// setup: divide by 2, period 6, zero high 2, one high 4 ticks
	localparam int          DEPTH  = 4;
	localparam logic [31:0] TIMING = 32'h0041_1800;
	localparam logic [31:0] CADDR  = led_link_pkg::CTRL_ADDR;
	localparam logic [31:0] DADDR  = led_link_pkg::DATA_ADDR;

	logic        clk_sys;
	logic        reset;
	logic        clkEn;
	logic [31:0] paddr;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        ledOut;
	logic        irqReq;
	int          n_errors    = 0;
	int          comparisons = 0;
	int          irqs        = 0;
	int          cycles      = 0;

	smart_led_serial_tx #(.DEPTH(DEPTH)) smart_led_serial_tx_inst (
		.clk_sys(clk_sys), .reset(reset), .clkEn(clkEn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ledOut(ledOut), .irqReq(irqReq));

	led_chain_model #(.ONE_CLK(8), .ZERO_CLK(4)) led_chain_model_inst (
		.clk_sys(clk_sys), .ledIn(ledOut));

	// ==========================================================
	// helpers
	task conclude();
		if (n_errors == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic apb(input logic [31:0] a, input logic w,
			input logic [31:0] d, output logic [31:0] r, output logic e);
		@(posedge clk_sys);
		psel    <= 1'b1;
		penable <= 1'b0;
		paddr   <= a;
		pwrite  <= w;
		pwdata  <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(a, 1'b1, d, r, e);
	endtask

	task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic        e;
		apb(a, 1'b0, 32'h0000_0000, r, e);
		check(r, exp);
	endtask

	function automatic logic [31:0] ctl(input logic wide, input logic latch,
			input logic irqSel);
		return TIMING | 32'h0000_0001 | (32'(wide) << 1) | (32'(latch) << 2)
			| (32'(irqSel) << 27);
	endfunction

	// collect one word of n bits from the chain, bit 0 first
	task automatic getWord(input int n, output logic [31:0] w);
		int k;
		w = 32'h0000_0000;
		k = 0;
		while (led_chain_model_inst.bits.size() < n && k < 2000) begin
			@(posedge clk_sys);
			k++;
		end
		for (int i = 0; i < n; i++)
			if (led_chain_model_inst.bits.size() > 0)
				w[i] = led_chain_model_inst.bits.pop_front();
	endtask

	// ==========================================================
	// clock, irq counter, timeout
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys) begin
		if (irqReq === 1'b1)
			irqs++;
		cycles++;
		if (cycles == 40000) begin
			n_errors++;
			conclude();
		end
	end

	// ==========================================================
	// tests; timing fields change while traffic is queued only at the disable write of the abort test
	initial begin : mainSeq
		logic [31:0] w;
		logic        e;
		int          k;
		reset = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
		clkEn = 1'b1;
		paddr = 32'h0000_0000; pwdata = 32'h0000_0000;
		repeat (5) @(posedge clk_sys);
		reset <= 1'b0;
		rdchk(CADDR, 32'h1000_0080);
		apb(32'h0000_0010, 1'b0, 32'h0000_0000, w, e);
		check(32'(e), 32'h0000_0001);
		// mixed widths, one entry each
		wr(CADDR, ctl(1'b0, 1'b0, 1'b1));
		irqs = 0;
		wr(DADDR, 32'hffa5_5a3c);
		wr(CADDR, ctl(1'b1, 1'b0, 1'b1));
		wr(DADDR, 32'h8123_4567);
		getWord(24, w);
		check(w, 32'h00a5_5a3c);
		getWord(32, w);
		check(w, 32'h8123_4567);
		check(32'(led_chain_model_inst.lastPeriod), 32'h0000_000c);
		check(32'(led_chain_model_inst.glitches), 32'h0000_0000);
		check(32'(irqs), 32'h0000_0002);
		// fill past full, status flags, below-half interrupt
		wr(CADDR, ctl(1'b0, 1'b0, 1'b0));
		irqs = 0;
		for (int i = 0; i < 6; i++)
			wr(DADDR, 32'h0000_0010 + 32'(i));
		rdchk(CADDR, ctl(1'b0, 1'b0, 1'b0) | 32'he000_0080);
		for (int i = 0; i < 5; i++) begin
			getWord(24, w);
			check(w, 32'h0000_0010 + 32'(i));
		end
		repeat (800) @(posedge clk_sys);
		check(32'(led_chain_model_inst.bits.size()), 32'h0000_0000);
		check(32'(irqs), 32'h0000_0001);
		// latch entry queued ahead of a data word
		wr(CADDR, ctl(1'b0, 1'b1, 1'b1));
		wr(DADDR, 32'hffff_ffff);
		wr(CADDR, ctl(1'b0, 1'b0, 1'b1));
		wr(DADDR, 32'h0000_0001);
		rdchk(CADDR, ctl(1'b0, 1'b0, 1'b1) | 32'h8000_0080);
		k = 0;
		while (ledOut !== 1'b1 && k < 5000) begin
			@(posedge clk_sys);
			k++;
		end
		check(32'(k >= 1505 && k < 1530), 32'h0000_0001);
		getWord(24, w);
		check(w, 32'h0000_0001);
		check(32'(led_chain_model_inst.bits.size()), 32'h0000_0000);
		// abort by disable in mid-word
		wr(CADDR, ctl(1'b1, 1'b0, 1'b1));
		wr(DADDR, 32'hffff_ffff);
		wr(DADDR, 32'hffff_ffff);
		irqs = 0;
		repeat (40) @(posedge clk_sys);
		// clock enable low must freeze the line mid-bit
		clkEn <= 1'b0;
		@(posedge clk_sys);
		w = {31'h0000_0000, ledOut};
		k = 0;
		repeat (20) begin
			@(posedge clk_sys);
			if (ledOut !== w[0])
				k++;
		end
		clkEn <= 1'b1;
		check(32'(k), 32'h0000_0000);
		wr(CADDR, 32'h0000_0000);
		repeat (2) @(posedge clk_sys);
		k = 0;
		repeat (1000) begin
			@(posedge clk_sys);
			if (ledOut !== 1'b0)
				k++;
		end
		check(32'(k), 32'h0000_0000);
		check(32'(irqs), 32'h0000_0000);
		rdchk(CADDR, 32'h1000_0080);
		conclude();
	end
endmodule // tb_smart_led_serial_tx
